// file: rtl/ptp_timer.sv
// Behaviour
// - Auto start selected: start timer at end of every transmission.
// - Auto start plus field-on start: start when RF field switches on.
// - Auto start, no multi-frame: 106 kbit/s modes stop after fifth bit.
// - Auto start, no multi-frame: other modes stop after fourth bit.
// - Multi-frame reception on: reception never stops the timer.
// - Writing halt bit as 1 stops a running timer.
// - Auto start off: protocol events neither start nor stop it.
// - Gate field: none, signal input, aux pin one, address pin three.
// - Active flag reflects enable, not gate level; gate ignores the flag.
// - Auto reload on: restart countdown from reload value at zero.
// - Auto reload off: count down to zero, then set zero flag.
// - Even divide off: tick rate is reference over 2P+1.
// - Even divide on: tick rate is reference over 2P+2.
// - Prescaler is mode low nibble above prescale-low byte, 12 bits.
// - Even divide select resets to 0.
// - Sixteen-bit reload value held in two writable bytes.
// - Reload value is loaded at each start event and at each auto reload at zero.
// - Current count readable as two read-only bytes.
`timescale 1ns/10ps
`default_nettype none
module ptp_timer
  import ptp_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              ref_clk_pin,
  input  wire logic              sig_input_pin,
  input  wire logic              aux_pin_one,
  input  wire logic              addr_pin_three,
  input  wire logic              tx_end,
  input  wire logic              rf_field_on,
  input  wire logic              rx_bit,
  input  wire logic              rx_mode_106,
  output logic                   count_active_flag,
  output logic                   countdown_zero_flag
);

  // All checks run on the bus clock and sleep through reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Register index of a byte address
  function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[ADDR_W-1:2];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic       ref_prev;
  logic [3:0] next_pin_meta;
  logic [3:0] next_pin_sync;
  logic       next_ref_prev;

  // Two flops per pin; bit 3 is the reference clock
  always_comb
  begin
    next_pin_meta = {ref_clk_pin, addr_pin_three, aux_pin_one, sig_input_pin};
    next_pin_sync = pin_meta;
    next_ref_prev = pin_sync[3];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      ref_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
      ref_prev <= next_ref_prev;
    end
  end

  // ----------------------------------------------------------------
  // Register write path
  // ----------------------------------------------------------------
  logic             aw_held, w_held;
  logic [IDX_W-1:0] aw_idx;
  logic [7:0]       w_byte;
  logic             w_lane0;
  logic [7:0]       timer_control_reg, prescale_low_reg, reload_high_reg, reload_low_reg;
  logic [2:0]       config_reg;
  logic             next_aw_held, next_w_held, next_lane0;
  logic [IDX_W-1:0] next_aw_idx;
  logic [7:0]       next_w_byte;
  logic [7:0]       next_tc, next_pl, next_rh, next_rl;
  logic [2:0]       next_cfg;
  logic             next_awready, next_wready, next_bvalid;
  logic [1:0]       next_bresp;
  logic             wr_fire, wr_hit, wr_map;
  logic             sw_start, sw_halt, sw_zero_clr;

  // Address and data are taken in either order; write once both are held
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_idx  = aw_idx;
    next_w_byte  = w_byte;
    next_lane0   = w_lane0;
    next_tc      = timer_control_reg;
    next_pl      = prescale_low_reg;
    next_rh      = reload_high_reg;
    next_rl      = reload_low_reg;
    next_cfg     = config_reg;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_idx  = reg_index(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_lane0  = s_axi_wstrb[0];
    end
    wr_fire = aw_held && w_held && !s_axi_bvalid;
    wr_map  = aw_idx inside {IDX_TIMER_CONTROL, IDX_PRESCALE_LOW, IDX_RELOAD_HIGH,
                             IDX_RELOAD_LOW, IDX_COUNT_HIGH, IDX_COUNT_LOW,
                             IDX_CONFIG, IDX_COMMAND, IDX_STATUS};
    wr_hit  = wr_fire && w_lane0;
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_map ? RESP_OKAY : RESP_SLVERR;
      if (wr_hit)
      begin
        case (aw_idx)
          IDX_TIMER_CONTROL: next_tc = w_byte;
          IDX_PRESCALE_LOW:  next_pl = w_byte;
          IDX_RELOAD_HIGH:   next_rh = w_byte;
          IDX_RELOAD_LOW:    next_rl = w_byte;
          IDX_CONFIG:        next_cfg = w_byte[2:0];
          default:           next_cfg = config_reg;
        endcase
      end
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    sw_start    = wr_hit && (aw_idx == IDX_COMMAND) && w_byte[CM_START];
    sw_halt     = wr_hit && (aw_idx == IDX_COMMAND) && w_byte[CM_HALT];
    sw_zero_clr = wr_hit && (aw_idx == IDX_STATUS) && w_byte[ST_ZERO];
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held           <= 1'b0;
      w_held            <= 1'b0;
      aw_idx            <= '0;
      w_byte            <= RST_BYTE;
      w_lane0           <= 1'b0;
      timer_control_reg <= RST_BYTE;
      prescale_low_reg  <= RST_BYTE;
      reload_high_reg   <= RST_BYTE;
      reload_low_reg    <= RST_BYTE;
      config_reg        <= RST_CFG;
      s_axi_awready     <= 1'b1;
      s_axi_wready      <= 1'b1;
      s_axi_bvalid      <= 1'b0;
      s_axi_bresp       <= RESP_OKAY;
    end
    else
    begin
      aw_held           <= next_aw_held;
      w_held            <= next_w_held;
      aw_idx            <= next_aw_idx;
      w_byte            <= next_w_byte;
      w_lane0           <= next_lane0;
      timer_control_reg <= next_tc;
      prescale_low_reg  <= next_pl;
      reload_high_reg   <= next_rh;
      reload_low_reg    <= next_rl;
      config_reg        <= next_cfg;
      s_axi_awready     <= next_awready;
      s_axi_wready      <= next_wready;
      s_axi_bvalid      <= next_bvalid;
      s_axi_bresp       <= next_bresp;
    end
  end

  // ----------------------------------------------------------------
  // Timer core
  // ----------------------------------------------------------------
  ptp_div_if  dvi ();
  logic [15:0] count_now, next_count;
  logic [15:0] reload_value;
  logic [2:0]  rx_bits, next_rx_bits;
  logic        field_prev, next_active, next_zero;
  logic        auto_start_sel, auto_reload_sel, multi_frame_rx, field_on_start;
  logic        gate_open, start_evt, rx_stop, zero_evt;
  ptp_gate_t   gate_source_sel;

  ptp_divider ptp_divider_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .dv      (dvi.div)
  );

  assign dvi.prescale = {timer_control_reg[TC_PRE_HI:0], prescale_low_reg};
  assign dvi.even_div = config_reg[CF_EVEN_DIV];
  assign dvi.run      = count_active_flag;
  assign dvi.ref_tick = pin_sync[3] && !ref_prev;

  // Start, stop, gate and countdown decisions; halt beats start beats stop
  always_comb
  begin
    auto_start_sel  = timer_control_reg[TC_AUTO_START];
    gate_source_sel = ptp_gate_t'(timer_control_reg[TC_GATE_HI:TC_GATE_LO]);
    auto_reload_sel = timer_control_reg[TC_AUTO_RELOAD];
    multi_frame_rx  = config_reg[CF_MULTI_RX];
    field_on_start  = config_reg[CF_FIELD_START];
    reload_value    = {reload_high_reg, reload_low_reg};
    case (gate_source_sel)
      PTP_GATE_NONE: gate_open = 1'b1;
      PTP_GATE_SIG:  gate_open = pin_sync[0];
      PTP_GATE_AUX:  gate_open = pin_sync[1];
      PTP_GATE_ADDR: gate_open = pin_sync[2];
      default:       gate_open = 1'b1;
    endcase
    start_evt = sw_start || (auto_start_sel && (tx_end
                || (field_on_start && rf_field_on && !field_prev)));
    rx_stop   = auto_start_sel && !multi_frame_rx && count_active_flag && rx_bit
                && (3'(rx_bits + 3'h1) == (rx_mode_106 ? RX_STOP_106
                                                        : RX_STOP_OTHER));
    zero_evt  = count_active_flag && gate_open && dvi.timer_tick && (count_now == 16'h0000);
    next_count   = count_now;
    next_active  = count_active_flag;
    next_rx_bits = rx_bits;
    next_zero    = countdown_zero_flag;
    if (count_active_flag && rx_bit && rx_bits != RX_STOP_106)
    begin
      next_rx_bits = 3'(rx_bits + 3'h1);
    end
    if (sw_zero_clr)
    begin
      next_zero = 1'b0;
    end
    if (zero_evt)
    begin
      next_zero = 1'b1;  // Set wins over a same-cycle clear
    end
    if (sw_halt)
    begin
      next_active = 1'b0;
    end
    else if (start_evt)
    begin
      next_active  = 1'b1;
      next_count   = reload_value;
      next_rx_bits = 3'h0;
    end
    else if (rx_stop)
    begin
      next_active = 1'b0;
    end
    else if (zero_evt)
    begin
      if (auto_reload_sel)
      begin
        next_count = reload_value;
      end
      else
      begin
        next_active = 1'b0;
      end
    end
    else if (count_active_flag && gate_open && dvi.timer_tick)
    begin
      next_count = 16'(count_now - 16'h0001);
    end
  end

  // Active flag tracks the enable only, so the gate pin never shows in it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_now           <= 16'h0000;
      count_active_flag   <= 1'b0;
      countdown_zero_flag <= 1'b0;
      rx_bits             <= 3'h0;
      field_prev          <= 1'b0;
    end
    else
    begin
      count_now           <= next_count;
      count_active_flag   <= next_active;
      countdown_zero_flag <= next_zero;
      rx_bits             <= next_rx_bits;
      field_prev          <= rf_field_on;
    end
  end

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  logic              next_arready, next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        next_rresp;
  logic [7:0]        rd_byte;
  logic              rd_map;

  // Data is sampled at the address handshake, answer one cycle later
  always_comb
  begin
    rd_map = 1'b1;
    case (reg_index(s_axi_araddr))
      IDX_TIMER_CONTROL: rd_byte = timer_control_reg;
      IDX_PRESCALE_LOW:  rd_byte = prescale_low_reg;
      IDX_RELOAD_HIGH:   rd_byte = reload_high_reg;
      IDX_RELOAD_LOW:    rd_byte = reload_low_reg;
      IDX_COUNT_HIGH:    rd_byte = count_now[15:8];
      IDX_COUNT_LOW:     rd_byte = count_now[7:0];
      IDX_CONFIG:        rd_byte = {5'h00, config_reg};
      IDX_COMMAND:       rd_byte = 8'h00;
      IDX_STATUS:        rd_byte = {6'h00, countdown_zero_flag, count_active_flag};
      default:
      begin
        rd_byte = 8'h00;
        rd_map  = 1'b0;
      end
    endcase
    next_arready = s_axi_arready;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rdata   = {24'h000000, rd_byte};
      next_rresp   = rd_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      next_arready = 1'b1;
      next_rvalid  = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_halt_stops : assert property (sw_halt |=> !count_active_flag)
    else $error("halt did not stop timer");
  a_tx_start_load : assert property (auto_start_sel && tx_end && !sw_halt
    |=> count_active_flag && count_now == $past(reload_value))
    else $error("transmission end did not start timer");
  a_field_start : assert property (auto_start_sel && field_on_start && rf_field_on
    && !field_prev && !sw_halt |=> count_active_flag)
    else $error("field on did not start timer");
  a_rx_stop_bits : assert property (rx_stop && !sw_halt && !start_evt
    |=> !count_active_flag)
    else $error("reception did not stop timer");
  a_multi_keeps : assert property (multi_frame_rx && count_active_flag && rx_bit
    && !sw_halt && !zero_evt |=> count_active_flag)
    else $error("multi-frame reception stopped timer");
  a_manual_ignore : assert property (!auto_start_sel && !count_active_flag
    && !sw_start |=> !count_active_flag)
    else $error("protocol started timer in manual mode");
  a_gate_holds : assert property (count_active_flag && !gate_open && !start_evt
    |=> $stable(count_now))
    else $error("count moved with gate closed");
  a_reload_restart : assert property (zero_evt && auto_reload_sel && !sw_halt
    && !start_evt |=> count_active_flag && count_now == $past(reload_value)
    && countdown_zero_flag)
    else $error("auto reload failed");
  a_zero_stop_flag : assert property (zero_evt && !auto_reload_sel && !sw_halt
    && !start_evt |=> !count_active_flag && countdown_zero_flag)
    else $error("zero did not stop and flag");

  c_zero_reached : cover property (zero_evt && !auto_reload_sel);
  c_reload_seen  : cover property (zero_evt && auto_reload_sel);
  c_rx_stopped   : cover property (rx_stop);
  c_gated_hold   : cover property (count_active_flag && !gate_open && dvi.timer_tick);

endmodule // ptp_timer
`default_nettype wire

// file: rtl/ptp_pkg.sv
package ptp_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 6;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TIMER_CONTROL = 6'h2A;
  localparam logic [IDX_W-1:0] IDX_PRESCALE_LOW  = 6'h2B;
  localparam logic [IDX_W-1:0] IDX_RELOAD_HIGH   = 6'h2C;
  localparam logic [IDX_W-1:0] IDX_RELOAD_LOW    = 6'h2D;
  localparam logic [IDX_W-1:0] IDX_COUNT_HIGH    = 6'h2E;
  localparam logic [IDX_W-1:0] IDX_COUNT_LOW     = 6'h2F;
  localparam logic [IDX_W-1:0] IDX_CONFIG        = 6'h3C;
  localparam logic [IDX_W-1:0] IDX_COMMAND       = 6'h3D;
  localparam logic [IDX_W-1:0] IDX_STATUS        = 6'h3E;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned TC_AUTO_START  = 7;
  localparam int unsigned TC_GATE_HI     = 6;
  localparam int unsigned TC_GATE_LO     = 5;
  localparam int unsigned TC_AUTO_RELOAD = 4;
  localparam int unsigned TC_PRE_HI      = 3;
  localparam int unsigned CF_EVEN_DIV    = 0;
  localparam int unsigned CF_MULTI_RX    = 1;
  localparam int unsigned CF_FIELD_START = 2;
  localparam int unsigned CM_START       = 0;
  localparam int unsigned CM_HALT        = 1;
  localparam int unsigned ST_ACTIVE      = 0;
  localparam int unsigned ST_ZERO        = 1;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_CFG  = 3'h0;

  // Gate sources
  typedef enum logic [1:0] {
    PTP_GATE_NONE = 2'h0,
    PTP_GATE_SIG  = 2'h1,
    PTP_GATE_AUX  = 2'h2,
    PTP_GATE_ADDR = 2'h3
  } ptp_gate_t;

  // Received bits after which the protocol stops the count
  localparam logic [2:0] RX_STOP_106   = 3'h5;
  localparam logic [2:0] RX_STOP_OTHER = 3'h4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Nominal reference frequency feeding the divider
  localparam int unsigned REF_FREQ_KHZ = 13560;

endpackage

// file: rtl/ptp_div_if.sv
`timescale 1ns/10ps
`default_nettype none
// Link between the timer core and its reference divider
interface ptp_div_if;
  logic [11:0] prescale;
  logic        even_div;
  logic        run;
  logic        ref_tick;
  logic        timer_tick;

  modport ctrl (output prescale, output even_div, output run, output ref_tick,
                input timer_tick);
  modport div  (input prescale, input even_div, input run, input ref_tick,
                output timer_tick);
endinterface
`default_nettype wire

// file: rtl/ptp_divider.sv
`timescale 1ns/10ps
`default_nettype none
module ptp_divider
  import ptp_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  ptp_div_if.div    dv
);

  logic [12:0] cnt;
  logic [12:0] next_cnt;
  logic        tick;
  logic        next_tick;
  logic [12:0] last;

  // ----------------------------------------------------------------
  // Divide reference ticks by 2P+1, or 2P+2 in even mode
  // ----------------------------------------------------------------
  always_comb
  begin
    last      = {dv.prescale, dv.even_div};
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!dv.run)
    begin
      next_cnt = '0;  // Restart phase so each start from a stopped timer sees a full period
    end
    else if (dv.ref_tick)
    begin
      if (cnt == last)
      begin
        next_cnt  = '0;
        next_tick = 1'b1;
      end
      else
      begin
        next_cnt = cnt + 13'h1;
      end
    end
  end

  // Register divider state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

  assign dv.timer_tick = tick;

  // Ticks only while the divider runs
  a_div_tick_run : assert property (@(posedge aclk) disable iff (!aresetn)
    dv.timer_tick |-> $past(dv.run) && $past(dv.ref_tick))
    else $error("timer tick without run or reference tick");

endmodule // ptp_divider
`default_nettype wire

// file: sim/test_protocol_timer_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module test_protocol_timer_prescaler
  import ptp_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus, clocks and design
  // ----------------------------------------------------------------
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic              rready = 1'b0, awready, wready, bvalid, arready, rvalid, act, zero;
  logic [1:0]        bresp, rresp, resp;
  logic              ref_clk = 1'b0, tx = 1'b0, field = 1'b0, rxb = 1'b0, m106 = 1'b0;
  logic [2:0]        gp = 3'h0;
  logic [7:0]        rd;
  int                mismatches = 0, compares = 0, refcnt = 0, t0;

  // Reference near 13.5 MHz, slow enough that the synchroniser sees every edge
  always #10 aclk = ~aclk;
  always #37 ref_clk = ~ref_clk;
  always @(posedge ref_clk) refcnt++;

  ptp_timer ptp_timer_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ref_clk_pin(ref_clk), .sig_input_pin(gp[0]), .aux_pin_one(gp[1]),
    .addr_pin_three(gp[2]), .tx_end(tx), .rf_field_on(field), .rx_bit(rxb),
    .rx_mode_106(m106), .count_active_flag(act), .countdown_zero_flag(zero)
  );

  // ----------------------------------------------------------------
  // Bus, event and checking tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic over();
    mismatches++;
    results();
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Upper data bits set on purpose: the block must ignore them
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    int n;
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {24'hFFFFFF, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (n == 100) over();
  endtask

  task automatic rdr(input logic [5:0] i);
    int n;
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
    if (n == 100) over();
  endtask

  task automatic rdc(input string nm, input logic [5:0] i, input logic [7:0] e);
    rdr(i);
    chk(nm, {24'h0, rd}, {24'h0, e});
  endtask

  task automatic txp();
    @(posedge aclk);
    tx <= 1'b1;
    @(posedge aclk);
    tx <= 1'b0;
  endtask

  task automatic rxp(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      rxb <= 1'b1;
      @(posedge aclk);
      rxb <= 1'b0;
    end
  endtask

  // Flag updates one edge after its cause; two edges leave margin
  task automatic ac(input logic e);
    repeat (2) @(posedge aclk);
    chk("active", act, e);
  endtask

  task automatic wz();
    int n;
    for (n = 0; n < 20000; n++)
    begin
      @(posedge aclk);
      if (zero === 1'b1) break;
    end
    if (n == 20000) over();
  endtask

  // Main sequence: reset, registers, protocol events, gates, rates
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 'h2A; i <= 'h2F; i++) rdc("reset_reg", i[5:0], 8'h00);
    rdc("config_reset", IDX_CONFIG, 8'h00);
    rdr(6'h00);
    chk("unmapped_resp", resp, RESP_SLVERR);
    wr(6'h00, 8'h00);
    chk("wr_unmapped_resp", resp, RESP_SLVERR);
    wr(IDX_RELOAD_HIGH, 8'hA5);
    wr(IDX_RELOAD_LOW, 8'h5A);
    chk("wr_resp", resp, RESP_OKAY);
    rdc("reload_low", IDX_RELOAD_LOW, 8'h5A);
    wr(IDX_TIMER_CONTROL, 8'h0F);
    wr(IDX_PRESCALE_LOW, 8'hFF);
    wr(IDX_COMMAND, 8'h01);
    rdc("count_high", IDX_COUNT_HIGH, 8'hA5);
    wr(IDX_RELOAD_HIGH, 8'h11);
    wr(IDX_COUNT_HIGH, 8'h00);
    rdc("count_high_kept", IDX_COUNT_HIGH, 8'hA5);
    wr(IDX_COMMAND, 8'h02);
    ac(1'b0);
    wr(IDX_TIMER_CONTROL, 8'h8F);
    for (int m = 1; m >= 0; m--)
    begin
      m106 <= m[0];
      txp();
      ac(1'b1);
      rxp(m + 3);
      ac(1'b1);
      rxp(1);
      ac(1'b0);
    end
    wr(IDX_CONFIG, 8'h02);
    txp();
    rxp(6);
    ac(1'b1);
    wr(IDX_COMMAND, 8'h02);
    ac(1'b0);
    wr(IDX_CONFIG, 8'h04);
    field <= 1'b1;
    ac(1'b1);
    wr(IDX_COMMAND, 8'h02);
    field <= 1'b0;
    wr(IDX_TIMER_CONTROL, 8'h0F);
    txp();
    field <= 1'b1;
    ac(1'b0);
    wr(IDX_COMMAND, 8'h01);
    rxp(5);
    ac(1'b1);
    wr(IDX_COMMAND, 8'h02);
    field <= 1'b0;
    wr(IDX_PRESCALE_LOW, 8'h00);
    wr(IDX_RELOAD_HIGH, 8'h00);
    wr(IDX_RELOAD_LOW, 8'h10);
    // Only the selected pin closes; the other two stay open to catch a wrong select
    for (int g = 1; g < 4; g++)
    begin
      gp <= 3'h7 ^ (3'h1 << (g - 1));
      wr(IDX_TIMER_CONTROL, {1'b0, g[1:0], 5'h00});
      wr(IDX_COMMAND, 8'h01);
      repeat (40) @(posedge aclk);
      rdc("gated_count", IDX_COUNT_LOW, 8'h10);
      chk("gated_active", act, 1'b1);
      gp <= 3'h7;
      wz();
      ac(1'b0);
      wr(IDX_STATUS, 8'h02);
    end
    wr(IDX_TIMER_CONTROL, 8'h10);
    wr(IDX_COMMAND, 8'h01);
    wz();
    ac(1'b1);
    rdc("status", IDX_STATUS, 8'h03);
    wr(IDX_COMMAND, 8'h02);
    wr(IDX_STATUS, 8'h02);
    chk("zero_cleared", zero, 1'b0);
    // Prescaler 0x100 and reload 7: eight timer ticks, odd then even divide
    wr(IDX_TIMER_CONTROL, 8'h01);
    wr(IDX_RELOAD_LOW, 8'h07);
    for (int e = 0; e < 2; e++)
    begin
      wr(IDX_CONFIG, e[7:0]);
      wr(IDX_COMMAND, 8'h01);
      t0 = refcnt;
      wz();
      t0 = refcnt - t0 - 8 * (513 + e);
      chk("ref_ticks", t0 >= -3 && t0 <= 3, 1'b1);
      wr(IDX_STATUS, 8'h02);
    end
    results();
  end
endmodule // test_protocol_timer_prescaler
`default_nettype wire
